// ===== design/aso_consts.vh
`ifndef ASO_CONSTS_VH
`define ASO_CONSTS_VH

// Register byte offsets on the Wishbone slave
`define ASO_OFF_CTRL       8'h00
`define ASO_OFF_SWCTL1     8'h04
`define ASO_OFF_SWCTL2     8'h08
`define ASO_OFF_SWSTAT     8'h0C
`define ASO_OFF_ACC        8'h10
`define ASO_OFF_IRQ_STAT   8'h14
`define ASO_OFF_IRQ_EN     8'h18
`define ASO_OFF_IRQ_CLR    8'h1C

// Control register fields
`define ASO_CTRL_AUTO      0
`define ASO_CTRL_TRIG      1
`define ASO_CTRL_OVR       2
`define ASO_CTRL_RGP       3
`define ASO_CTRL_RST       4'h1

// Accessory status fields
`define ASO_ACC_3POLE      0
`define ASO_ACC_STD        1
`define ASO_ACC_RING2      2
`define ASO_ACC_INS        3
`define ASO_ACC_AWAKE      4
`define ASO_ACC_BUSY       5

// Interrupt bits
`define ASO_IRQ_INSREM     0
`define ASO_IRQ_DONE       1

// Switch status field position of the second switch group
`define ASO_SWSTAT_SW2     8

// Detected type codes from the detector
`define ASO_TYPE_NONE      2'h0
`define ASO_TYPE_3POLE     2'h1
`define ASO_TYPE_STD       2'h2
`define ASO_TYPE_RING2     2'h3

// Switch group 1: [5] sleeve gnd, [4] ring2 gnd, [3] sleeve depl, [2] ring2 depl, [1:0] mic
`define ASO_SW1_NOINS      6'h0C
`define ASO_SW1_3POLE      6'h3C
`define ASO_SW1_STD        6'h15
`define ASO_SW1_RING2      6'h2A
`define ASO_SW1_DEPL_MASK  6'h0C
`define ASO_SW2_NOINS      4'h0
`define ASO_SW2_3POLE      4'h0
`define ASO_SW2_STD        4'h5
`define ASO_SW2_RING2      4'hA

// Register reset values
`define ASO_SWCTL1_RST     6'h00
`define ASO_SWCTL2_RST     4'h0

`endif

// ===== design/aso_sync.v
`timescale 1ns/1ps
`default_nettype none

module aso_sync (
  input  wire mclk,
  input  wire srst,
  input  wire async_in,
  output wire sync_out
);

  reg meta_q;
  reg sync_q;

  // The first stage feeds only the second stage
  always @(posedge mclk) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // aso_sync

`default_nettype wire

// ===== design/aso_irq.v
`timescale 1ns/1ps
`default_nettype none

module aso_irq (
  input  wire       mclk,
  input  wire       srst,
  input  wire [1:0] event_set,
  input  wire       en_we,
  input  wire [1:0] en_wdata,
  input  wire       clr_we,
  input  wire [1:0] clr_wdata,
  output wire [1:0] status,
  output wire [1:0] enable,
  output wire       irq
);

  reg [1:0] stat_q;
  reg [1:0] en_q;
  genvar    i;

  generate
    for (i = 0; i < 2; i = i + 1) begin : g_bit
      // A new event in the clear cycle survives the clear
      always @(posedge mclk) begin
        if (srst) begin
          stat_q[i] <= 1'b0;
        end else if (event_set[i]) begin
          stat_q[i] <= 1'b1;
        end else if (clr_we && clr_wdata[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (srst) begin
      en_q <= 2'h0;
    end else if (en_we) begin
      en_q <= en_wdata;
    end
  end

  assign status = stat_q;
  assign enable = en_q;
  assign irq    = |(stat_q & en_q);

endmodule // aso_irq

`default_nettype wire

// ===== design/aso_top.v
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "aso_consts.vh"

module aso_top (
  input  wire        mclk,
  input  wire        srst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        jack_ins_pin,
  input  wire        debounce_busy,
  output wire        det_start,
  input  wire        det_done,
  input  wire [1:0]  det_type,
  output wire [5:0]  sw_ctl1,
  output wire [3:0]  sw_ctl2,
  output wire        awake,
  output wire        irq
);

  // Bus slave
  reg         ack_q;
  reg  [31:0] rdat_q;
  reg  [31:0] rdat_d;
  wire        req;
  wire        wr_lo;

  // Software registers
  reg         auto_en_q;
  reg         trig_q;
  reg         ovr_q;
  reg         rgp_mode_q;
  reg  [5:0]  swc1_q;
  reg  [3:0]  swc2_q;

  // Copies actually applied to the switches
  reg         ovr_eff_q;
  reg  [5:0]  swc1_eff_q;
  reg  [3:0]  swc2_eff_q;

  // Insertion and detection state
  wire        ins_s;
  reg         ins_q;
  wire        ins_rise;
  wire        ins_fall;
  reg         busy_q;
  reg         det_start_q;
  reg         det_valid_q;
  reg  [1:0]  type_q;
  wire        det_go;
  wire        trig_consume;
  wire        hold_off;

  // Switch outputs
  reg  [5:0]  sw1_q;
  reg  [3:0]  sw2_q;
  reg  [5:0]  sw1_d;
  reg  [3:0]  sw2_d;

  // Interrupts
  wire [1:0]  irq_stat;
  wire [1:0]  irq_en;
  wire [1:0]  irq_ev;
  wire        en_we;
  wire        clr_we;

  localparam [3:0] CTRL_RST_VAL = `ASO_CTRL_RST;

  function hit;
    input [7:0] adr;
    input [7:0] off;
    begin
      hit = (adr[7:2] == off[7:2]);
    end
  endfunction

  function [5:0] sw1_cfg;
    input [1:0] t;
    input       rgp;
    reg   [5:0] v;
    begin
      v = `ASO_SW1_NOINS;
      case (t)
        `ASO_TYPE_3POLE: v = `ASO_SW1_3POLE;
        `ASO_TYPE_STD:   v = `ASO_SW1_STD;
        `ASO_TYPE_RING2: v = `ASO_SW1_RING2;
        default:         v = `ASO_SW1_NOINS;
      endcase
      // Ground must pass the low-resistance switches only, for the antenna path
      sw1_cfg = rgp ? (v & ~`ASO_SW1_DEPL_MASK) : v;
    end
  endfunction

  function [3:0] sw2_cfg;
    input [1:0] t;
    begin
      case (t)
        `ASO_TYPE_3POLE: sw2_cfg = `ASO_SW2_3POLE;
        `ASO_TYPE_STD:   sw2_cfg = `ASO_SW2_STD;
        `ASO_TYPE_RING2: sw2_cfg = `ASO_SW2_RING2;
        default:         sw2_cfg = `ASO_SW2_NOINS;
      endcase
    end
  endfunction

  // Classic Wishbone: ack one cycle after the strobe, writes land on the ack edge
  assign req   = wb_cyc_i && wb_stb_i;
  assign wr_lo = req && wb_we_i && ack_q && wb_sel_i[0];

  always @* begin
    rdat_d = 32'h0000_0000;
    if (hit(wb_adr_i, `ASO_OFF_CTRL)) begin
      rdat_d[`ASO_CTRL_AUTO] = auto_en_q;
      rdat_d[`ASO_CTRL_TRIG] = trig_q;
      rdat_d[`ASO_CTRL_OVR]  = ovr_q;
      rdat_d[`ASO_CTRL_RGP]  = rgp_mode_q;
    end else if (hit(wb_adr_i, `ASO_OFF_SWCTL1)) begin
      rdat_d[5:0] = swc1_q;
    end else if (hit(wb_adr_i, `ASO_OFF_SWCTL2)) begin
      rdat_d[3:0] = swc2_q;
    end else if (hit(wb_adr_i, `ASO_OFF_SWSTAT)) begin
      rdat_d[5:0] = sw1_q;
      rdat_d[`ASO_SWSTAT_SW2+3:`ASO_SWSTAT_SW2] = sw2_q;
    end else if (hit(wb_adr_i, `ASO_OFF_ACC)) begin
      rdat_d[`ASO_ACC_3POLE] = det_valid_q && (type_q == `ASO_TYPE_3POLE);
      rdat_d[`ASO_ACC_STD]   = det_valid_q && (type_q == `ASO_TYPE_STD);
      rdat_d[`ASO_ACC_RING2] = det_valid_q && (type_q == `ASO_TYPE_RING2);
      rdat_d[`ASO_ACC_INS]   = ins_q;
      rdat_d[`ASO_ACC_AWAKE] = awake;
      rdat_d[`ASO_ACC_BUSY]  = busy_q;
    end else if (hit(wb_adr_i, `ASO_OFF_IRQ_STAT)) begin
      rdat_d[1:0] = irq_stat;
    end else if (hit(wb_adr_i, `ASO_OFF_IRQ_EN)) begin
      rdat_d[1:0] = irq_en;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && !ack_q;
      if (req && !ack_q && !wb_we_i) begin
        rdat_q <= rdat_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Insertion pin comes from the jack comparator, outside this clock
  aso_sync i_aso_sync (
    .mclk     (mclk),
    .srst     (srst),
    .async_in (jack_ins_pin),
    .sync_out (ins_s)
  );

  assign ins_rise = ins_s && !ins_q;
  assign ins_fall = !ins_s && ins_q;

  // A pending trigger fires at insertion or, once inserted, as soon as idle
  assign det_go = !busy_q && !ins_fall &&
                  ((ins_rise && (auto_en_q || trig_q)) || (ins_q && trig_q));
  assign trig_consume = ins_rise || det_go;

  always @(posedge mclk) begin
    if (srst) begin
      auto_en_q  <= CTRL_RST_VAL[`ASO_CTRL_AUTO];
      trig_q     <= 1'b0;
      ovr_q      <= 1'b0;
      rgp_mode_q <= 1'b0;
      swc1_q     <= `ASO_SWCTL1_RST;
      swc2_q     <= `ASO_SWCTL2_RST;
    end else begin
      if (wr_lo && hit(wb_adr_i, `ASO_OFF_CTRL)) begin
        auto_en_q  <= wb_dat_i[`ASO_CTRL_AUTO];
        trig_q     <= wb_dat_i[`ASO_CTRL_TRIG];
        ovr_q      <= wb_dat_i[`ASO_CTRL_OVR];
        rgp_mode_q <= wb_dat_i[`ASO_CTRL_RGP];
      end else if (trig_consume) begin
        trig_q <= 1'b0;
      end
      if (wr_lo && hit(wb_adr_i, `ASO_OFF_SWCTL1)) begin
        swc1_q <= wb_dat_i[5:0];
      end
      if (wr_lo && hit(wb_adr_i, `ASO_OFF_SWCTL2)) begin
        swc2_q <= wb_dat_i[3:0];
      end
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      ins_q       <= 1'b0;
      busy_q      <= 1'b0;
      det_start_q <= 1'b0;
      det_valid_q <= 1'b0;
      type_q      <= `ASO_TYPE_NONE;
    end else begin
      ins_q       <= ins_s;
      det_start_q <= det_go;
      if (ins_fall) begin
        busy_q      <= 1'b0;
        det_valid_q <= 1'b0;
        type_q      <= `ASO_TYPE_NONE;
      end else begin
        if (ins_rise) begin
          // Flags of the previous accessory must not leak into the new one
          det_valid_q <= 1'b0;
          type_q      <= `ASO_TYPE_NONE;
        end
        if (det_go) begin
          busy_q <= 1'b1;
        end else if (busy_q && det_done) begin
          busy_q      <= 1'b0;
          det_valid_q <= (det_type != `ASO_TYPE_NONE);
          type_q      <= det_type;
        end
      end
    end
  end

  assign det_start = det_start_q;

  // Override and manual switch settings reach the switches only while no detection runs or starts and debounce is idle
  assign hold_off = busy_q || det_go || debounce_busy;

  always @(posedge mclk) begin
    if (srst) begin
      ovr_eff_q  <= 1'b0;
      swc1_eff_q <= `ASO_SWCTL1_RST;
      swc2_eff_q <= `ASO_SWCTL2_RST;
    end else if (!hold_off) begin
      ovr_eff_q  <= ovr_q;
      swc1_eff_q <= swc1_q;
      swc2_eff_q <= swc2_q;
    end
  end

  always @* begin
    if (ovr_eff_q) begin
      sw1_d = swc1_eff_q;
      sw2_d = swc2_eff_q;
    end else if (ins_q && det_valid_q) begin
      sw1_d = sw1_cfg(type_q, rgp_mode_q);
      sw2_d = sw2_cfg(type_q);
    end else begin
      sw1_d = `ASO_SW1_NOINS;
      sw2_d = `ASO_SW2_NOINS;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      sw1_q <= `ASO_SW1_NOINS;
      sw2_q <= `ASO_SW2_NOINS;
    end else begin
      sw1_q <= sw1_d;
      sw2_q <= sw2_d;
    end
  end

  assign sw_ctl1 = sw1_q;
  assign sw_ctl2 = sw2_q;

  // Sleep only with no accessory and no override, written or pending
  assign awake = ins_q || ovr_q || ovr_eff_q;

  assign irq_ev[`ASO_IRQ_INSREM] = ins_rise || ins_fall;
  assign irq_ev[`ASO_IRQ_DONE]   = busy_q && det_done && !ins_fall;
  assign en_we  = wr_lo && hit(wb_adr_i, `ASO_OFF_IRQ_EN);
  assign clr_we = wr_lo && hit(wb_adr_i, `ASO_OFF_IRQ_CLR);

  aso_irq i_aso_irq (
    .mclk      (mclk),
    .srst      (srst),
    .event_set (irq_ev),
    .en_we     (en_we),
    .en_wdata  (wb_dat_i[1:0]),
    .clr_we    (clr_we),
    .clr_wdata (wb_dat_i[1:0]),
    .status    (irq_stat),
    .enable    (irq_en),
    .irq       (irq)
  );

endmodule // aso_top

`default_nettype wire

// ===== tb/aso_det_model.sv
`timescale 1ns/1ps
`default_nettype none

module aso_det_model (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       det_start,
  input  wire logic [1:0] acc_type,
  input  wire logic [3:0] lag,
  output var  logic       det_done = 1'b0,
  output var  logic [1:0] det_type = 2'h0
);
  logic       busy_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;

  always @(posedge mclk) begin
    det_done <= 1'b0;
    // Type is only valid with done; toggling elsewhere exposes a sloppy sample
    det_type <= ~det_type;
    if (srst) begin
      busy_q <= 1'b0;
    end else if (det_start) begin
      busy_q <= 1'b1;
      cnt_q  <= lag;
    end else if (busy_q && cnt_q == 4'h0) begin
      busy_q   <= 1'b0;
      det_done <= 1'b1;
      det_type <= acc_type;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // aso_det_model

`default_nettype wire

// ===== tb/aso_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module aso_top_props (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        jack_ins_pin,
  input wire logic        det_start,
  input wire logic [5:0]  sw_ctl1,
  input wire logic [3:0]  sw_ctl2,
  input wire logic        awake,
  input wire logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  a_ack_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] >= 6'h07
    |-> wb_dat_o == 32'h0) else $error("nonzero read data");
  a_start_pulse: assert property (det_start |=> !det_start) else $error("start long");
  a_start_awake: assert property (det_start |-> awake) else $error("start, no jack");
  a_ins_awake: assert property (jack_ins_pin [*4] |-> awake) else $error("asleep");
  // Four idle samples cover the deferred switch update after override or removal
  a_sleep_noins: assert property (!awake [*4] |-> sw_ctl1 == 6'h0C && sw_ctl2 == 4'h0)
    else $error("switches not idle");
  a_reset_state: assert property (disable iff (1'b0) srst |=> sw_ctl1 == 6'h0C
    && sw_ctl2 == 4'h0 && !irq && !det_start) else $error("bad reset state");
endmodule // aso_top_props

bind aso_top aso_top_props i_aso_top_props (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .jack_ins_pin, .det_start, .sw_ctl1, .sw_ctl2, .awake, .irq);

`default_nettype wire

// ===== tb/tb_aso_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aso_consts.vh"

module tb_aso_top;
  logic mclk, srst, cyc, stb, we, pin, dbb, done, ovr, auto, trig, rgp, run;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, starts = 32'h0, s0, seed_v;
  logic [1:0]  dtype, atype, en;
  logic [3:0]  lag, sw2, ctl2, sel, sel_v;
  logic [5:0]  sw1, ctl1;
  logic        dstart, ack, awake, irq;
  int          error_cnt, samples_checked, i;

  aso_top i_aso_top (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .jack_ins_pin(pin), .debounce_busy(dbb), .det_start(dstart), .det_done(done),
    .det_type(dtype), .sw_ctl1(ctl1), .sw_ctl2(ctl2), .awake(awake), .irq(irq));
  aso_det_model i_aso_det_model (.mclk(mclk), .srst(srst), .det_start(dstart),
    .acc_type(atype), .lag(lag), .det_done(done), .det_type(dtype));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (dstart === 1'b1) starts <= starts + 32'h1;

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge mclk);
    {cyc, stb, we, sel, adr, dat} <= {2'b11, w, sel_v, a, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      end_of_test();
    end
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Status readback and the switch pins themselves must both match
  task automatic rsw(input logic [31:0] e);
    rdc(`ASO_OFF_SWSTAT, e);
    chk({20'h0, ctl2, 2'h0, ctl1}, e);
  endtask
  // Longest path: pin sync 2, start 1, detector lag 15, switch update 2
  task automatic settle();
    repeat (24) @(posedge mclk);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] t, input logic g);
    logic [5:0] a;
    logic [3:0] b;
    case (t)
      2'h1: {a, b} = {`ASO_SW1_3POLE, `ASO_SW2_3POLE};
      2'h2: {a, b} = {`ASO_SW1_STD, `ASO_SW2_STD};
      2'h3: {a, b} = {`ASO_SW1_RING2, `ASO_SW2_RING2};
      default: {a, b} = {`ASO_SW1_NOINS, `ASO_SW2_NOINS};
    endcase
    if (t != 2'h0 && g) a = a & ~`ASO_SW1_DEPL_MASK;
    return {20'h0, b, 2'h0, a};
  endfunction
  // Inserted and awake, plus the one-hot type flag
  function automatic logic [31:0] fl(input logic [1:0] t);
    return (t == 2'h0) ? 32'h18 : (32'h18 | (32'h1 << (t - 2'h1)));
  endfunction

  initial begin
    {cyc, stb, we, sel, adr, dat, pin, dbb, atype, lag} = '0;
    sel_v = 4'hF;
    error_cnt = 0;
    samples_checked = 0;
    srst = 1'b1;
    seed_v = $urandom(32'h947E4AAA);
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rdc(`ASO_OFF_CTRL, 32'h1);
    rsw(32'hC);
    rdc(`ASO_OFF_ACC, 32'h0);
    rdc(8'h20, 32'h0);
    rdc(`ASO_OFF_IRQ_CLR, 32'h0);
    for (i = 0; i < 16; i++) begin
      {ovr, auto, trig} = i[2:0];
      {rgp, en, sw1, sw2, lag} = 17'($urandom);
      atype = 2'($urandom % 4);
      run = auto | trig;
      wr(`ASO_OFF_IRQ_EN, {30'h0, en});
      wr(`ASO_OFF_SWCTL1, {26'h0, sw1});
      wr(`ASO_OFF_SWCTL2, {28'h0, sw2});
      wr(`ASO_OFF_CTRL, {28'h0, rgp, ovr, trig, auto});
      s0 = starts;
      pin <= 1'b1;
      settle();
      chk(starts - s0, 32'(run));
      rdc(`ASO_OFF_CTRL, {28'h0, rgp, ovr, 1'b0, auto});
      rdc(`ASO_OFF_ACC, fl(run ? atype : 2'h0));
      rsw(ovr ? {20'h0, sw2, 2'h0, sw1} : cfg(run ? atype : 2'h0, rgp));
      rdc(`ASO_OFF_IRQ_STAT, {30'h0, run, 1'b1});
      chk(32'(irq), 32'(|({run, 1'b1} & en)));
      if (ovr && !run) begin
        wr(`ASO_OFF_CTRL, {28'h0, rgp, 2'b00, auto});
        settle();
        rsw(32'hC);
      end
      if (ovr && run) begin
        atype = 2'(1 + $urandom % 3);
        wr(`ASO_OFF_CTRL, {28'h0, rgp, 2'b11, auto});
        settle();
        rdc(`ASO_OFF_ACC, fl(atype));
        rsw({20'h0, sw2, 2'h0, sw1});
        wr(`ASO_OFF_CTRL, {28'h0, rgp, 2'b00, auto});
        settle();
        rsw(cfg(atype, rgp));
      end
      wr(`ASO_OFF_IRQ_CLR, 32'h3);
      rdc(`ASO_OFF_IRQ_STAT, 32'h0);
      chk(32'(irq), 32'h0);
      pin <= 1'b0;
      settle();
      wr(`ASO_OFF_IRQ_CLR, 32'h3);
    end
    dbb <= 1'b1;
    wr(`ASO_OFF_SWCTL1, 32'h2B);
    wr(`ASO_OFF_CTRL, 32'h5);
    settle();
    rsw(32'hC);
    chk(32'(awake), 32'h1);
    dbb <= 1'b0;
    settle();
    rsw({20'h0, sw2, 8'h2B});
    // A write without the low byte lane must leave the register alone
    sel_v = 4'hE;
    wr(`ASO_OFF_SWCTL1, 32'h3F);
    sel_v = 4'hF;
    rdc(`ASO_OFF_SWCTL1, 32'h2B);
    wr(`ASO_OFF_CTRL, 32'h1);
    settle();
    chk(32'(awake), 32'h0);
    end_of_test();
  end
endmodule // tb_aso_top

`default_nettype wire
